// ==== verilog/adst_pkg.sv ====
// constants and types shared by the display strobe timing generator
// assumes a single core clock and settings held stable during an access
package adst_pkg;

  // setting, step accumulator and parallel data widths
  localparam int SW = 8;
  localparam int AW = 20;
  localparam int DW = 16;

  // core cycles per half interface clock, serial bits per access
  localparam int HALF_DIV_DEF = 1;
  localparam int SER_BITS_DEF = 8;
  localparam int PW = 8;

  // reset values
  localparam logic [PW-1:0] PRESC_RST = 8'h00;
  localparam logic [AW-1:0] ACC_RST   = 20'h00000;
  localparam logic          PIN_RST   = 1'h1;

  // strobe setting slots and polarity bits
  localparam int NSTB    = 4;
  localparam int STB_CS  = 0;
  localparam int STB_RS  = 1;
  localparam int STB_RD  = 2;
  localparam int STB_WR  = 3;
  localparam int POL_SCK = 4;
  localparam int NPOL    = 5;
  localparam int NKIND   = 3;

  // entries compared against the access-wide step count
  localparam int A_CS_F   = 0;
  localparam int A_CS_R   = 1;
  localparam int A_RS_F   = 2;
  localparam int A_RS_R   = 3;
  localparam int A_STB_F  = 4;
  localparam int A_STB_R  = 5;
  localparam int A_LEN    = 6;
  localparam int A_SAMPLE = 7;
  localparam int A_OFFSET = 8;
  localparam int A_SRS_AS = 9;
  localparam int A_SRS_RL = 10;
  localparam int N_ACC    = 11;
  localparam logic [N_ACC-1:0] ACC_WHOLE = 11'h7C0;

  // entries compared against the serial slot step count
  localparam int S_SCK_F = 0;
  localparam int S_SCK_R = 1;
  localparam int S_LEN   = 2;
  localparam int S_TAIL  = 3;
  localparam int N_SLOT  = 4;
  localparam logic [N_SLOT-1:0] SLOT_WHOLE = 4'hC;

  typedef enum logic [1:0] {
    KIND_READ = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_DATA = 2'h2
  } adst_kind_type;

  typedef enum logic [2:0] {
    MODE_P80 = 3'h0,
    MODE_P68 = 3'h1,
    MODE_S3  = 3'h2,
    MODE_S4  = 3'h3,
    MODE_S5  = 3'h4
  } adst_mode_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_SHIFT = 3'h3,
    ST_TAIL  = 3'h2,
    ST_END   = 3'h6
  } adst_state_type;

endpackage

// ==== verilog/adst_step_if.sv ====
// step position carrier between the counter and the edge comparators
// assumes both ends sit on core_clk
`timescale 1ns/1ns
`default_nettype none
interface adst_step_if;
  logic [adst_pkg::AW-1:0] acc_h;   // half steps times divider setting
  logic [adst_pkg::AW-1:0] acc_w;   // whole steps times divider setting
  modport drive (output acc_h, output acc_w);
  modport cmp   (input acc_h, input acc_w);
endinterface
`default_nettype wire

// ==== verilog/adst_edge_cmp.sv ====
// per-entry edge comparators against a step position
// assumes the step accumulators grow by the divider setting per step
`timescale 1ns/1ns
`default_nettype none
module adst_edge_cmp #(
  parameter int                N     = 1,     // number of entries
  parameter logic [N-1:0]      WHOLE = '0     // entry counts whole steps
) (
  adst_step_if.cmp                        step,    // step position
  input  wire logic [N-1:0][adst_pkg::SW-1:0] setting, // edge settings
  output logic [N-1:0]                    reached  // edge passed
);
  import adst_pkg::*;

  // t*P >= 2X means t >= ceil(2X/P) with no divider needed
  for (genvar i = 0; i < N; i++) begin : g_ent
    if (WHOLE[i]) begin : g_w
      assign reached[i] = step.acc_w >= AW'(setting[i]);
    end else begin : g_h
      assign reached[i] = step.acc_h >= (AW'(setting[i]) << 1);
    end
  end
endmodule
`default_nettype wire

// ==== verilog/adst_pin_sync.sv ====
// three-stage synchroniser for inputs arriving from the display pins
// assumes the pins are asynchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module adst_pin_sync #(
  parameter int W = 1                       // bits
) (
  input  wire logic         core_clk,       // core clock
  input  wire logic         rst,            // async reset, high
  input  wire logic [W-1:0] d,              // pin level
  output logic      [W-1:0] q               // filtered level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // chain, then accept a change once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/adst_timing_gen.sv ====
// strobe timing generator for a parallel or serial display panel port
// assumes settings stay stable while an access runs
`timescale 1ns/1ns
`default_nettype none
module adst_timing_gen #(
  parameter int HALF_DIV = adst_pkg::HALF_DIV_DEF, // core cycles per half
  parameter int SER_BITS = adst_pkg::SER_BITS_DEF  // serial bits
) (
  input  wire logic                     core_clk,     // core clock
  input  wire logic                     rst,          // async reset, high
  input  wire adst_pkg::adst_mode_type  interface_mode, // port form
  input  wire logic [adst_pkg::NPOL-1:0] strobe_polarity_select, // 1=high
  input  wire logic [adst_pkg::SW-1:0]  base_clock_divider_setting, // P
  input  wire logic [adst_pkg::NKIND-1:0][adst_pkg::SW-1:0]
                                        interface_cycle_length_setting,
  input  wire logic [adst_pkg::NSTB-1:0][adst_pkg::SW-1:0]
                                        strobe_fall_setting, // per strobe
  input  wire logic [adst_pkg::NSTB-1:0][adst_pkg::SW-1:0]
                                        strobe_rise_setting, // per strobe
  input  wire logic [adst_pkg::SW-1:0]  read_sample_setting,   // sample
  input  wire logic [adst_pkg::SW-1:0]  serial_clock_delay_setting, // delay
  input  wire logic [adst_pkg::SW-1:0]  regsel_assert_setting,  // serial rs
  input  wire logic [adst_pkg::SW-1:0]  regsel_release_setting, // serial rs
  input  wire logic [adst_pkg::SW-1:0]  chipsel_release_setting, // cs tail
  input  wire logic                     access_req,   // request access
  input  wire adst_pkg::adst_kind_type  access_kind,  // access type
  input  wire logic [adst_pkg::DW-1:0]  access_wdata, // write word
  output logic                          access_ready, // idle, can take
  output logic                          access_done,  // access ended
  output logic [adst_pkg::DW-1:0]       access_rdata, // read word
  output logic                          chip_select_pin,  // cs pin
  output logic                          register_select,  // rs pin
  output logic                          read_strobe_pin,  // rd or r/w pin
  output logic                          write_strobe_pin, // wr or e pin
  output logic [adst_pkg::DW-1:0]       par_data_out,     // bus out
  output logic                          par_data_oe,      // bus drive
  input  wire logic [adst_pkg::DW-1:0]  par_data_in,      // bus in
  output logic                          serial_clock_pin, // serial clock
  output logic                          serial_data_out,  // serial out
  output logic                          serial_data_output_enable, // drive
  input  wire logic                     serial_data_in    // serial in
);
  import adst_pkg::*;

  adst_state_type     state_r;
  adst_state_type     state_nxt;
  adst_kind_type      kind_r;
  logic [PW-1:0]      presc_r;
  logic               tick;
  logic [SW-1:0]      per;
  logic               a_odd_r, s_odd_r, slot_clr, slot_go;
  logic               is_ser, is_read;
  logic [N_ACC-1:0]   ra;
  logic [N_SLOT-1:0]  rs;
  logic [N_ACC-1:0][SW-1:0]  a_set;
  logic [N_SLOT-1:0][SW-1:0] s_set;
  logic [DW-1:0]      wdata_r;
  logic [DW-1:0]      shift_r;
  logic [DW-1:0]      par_in_s;
  logic               ser_in_s;
  logic               bit_r, sampled_r, rose_r;
  logic [7:0]         bitcnt_r;
  logic               slot_end, last_bit, take;
  logic               cs_act, rs_act, rd_act, wr_act, sck_act, stb_act;

  adst_step_if acc_if ();
  adst_step_if slot_if ();

  // a zero divider would freeze every edge, so treat it as one
  assign per     = (base_clock_divider_setting == '0) ?
                   SW'(1) : base_clock_divider_setting;
  assign is_ser  = interface_mode inside {MODE_S3, MODE_S4, MODE_S5};
  assign is_read = (kind_r == KIND_READ);
  assign take    = access_req && (state_r == ST_IDLE);
  assign access_ready = (state_r == ST_IDLE);

  // half-step prescaler on the core clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_r <= PRESC_RST;
    end else if (state_r == ST_IDLE || presc_r == PW'(HALF_DIV - 1)) begin
      presc_r <= PRESC_RST;
    end else begin
      presc_r <= presc_r + PW'(1);
    end
  end
  assign tick = (state_r != ST_IDLE) && (presc_r == PW'(HALF_DIV - 1));

  // access-wide step position, restarted when idle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_if.acc_h <= ACC_RST;
      acc_if.acc_w <= ACC_RST;
      a_odd_r      <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      acc_if.acc_h <= ACC_RST;
      acc_if.acc_w <= ACC_RST;
      a_odd_r      <= 1'b0;
    end else if (tick) begin
      acc_if.acc_h <= acc_if.acc_h + AW'(per);
      a_odd_r      <= ~a_odd_r;
      if (a_odd_r) begin
        acc_if.acc_w <= acc_if.acc_w + AW'(per);
      end
    end
  end

  // serial slot step position; a boundary cycle is step zero of the next
  // slot, so a tick there already counts step one and no cycle is lost
  assign slot_clr = (state_r == ST_IDLE) || (state_r == ST_LEAD) ||
                    ((state_r == ST_SHIFT) && slot_end);
  assign slot_go  = tick && (slot_end || ((state_r == ST_LEAD) &&
                                          ra[A_OFFSET]));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_if.acc_h <= ACC_RST;
      slot_if.acc_w <= ACC_RST;
      s_odd_r       <= 1'b0;
    end else if (slot_clr) begin
      slot_if.acc_h <= slot_go ? AW'(per) : ACC_RST;
      slot_if.acc_w <= ACC_RST;
      s_odd_r       <= slot_go;
    end else if (tick) begin
      slot_if.acc_h <= slot_if.acc_h + AW'(per);
      s_odd_r       <= ~s_odd_r;
      if (s_odd_r) begin
        slot_if.acc_w <= slot_if.acc_w + AW'(per);
      end
    end
  end

  // settings routed to the access-wide comparators
  always_comb begin
    a_set[A_CS_F]   = strobe_fall_setting[STB_CS];
    a_set[A_CS_R]   = strobe_rise_setting[STB_CS];
    a_set[A_RS_F]   = strobe_fall_setting[STB_RS];
    a_set[A_RS_R]   = strobe_rise_setting[STB_RS];
    a_set[A_STB_F]  = is_read ? strobe_fall_setting[STB_RD] :
                                strobe_fall_setting[STB_WR];
    a_set[A_STB_R]  = is_read ? strobe_rise_setting[STB_RD] :
                                strobe_rise_setting[STB_WR];
    a_set[A_LEN]    = interface_cycle_length_setting[kind_r];
    a_set[A_SAMPLE] = read_sample_setting;
    a_set[A_OFFSET] = serial_clock_delay_setting;
    a_set[A_SRS_AS] = regsel_assert_setting;
    a_set[A_SRS_RL] = regsel_release_setting;
  end

  // settings routed to the serial slot comparators
  always_comb begin
    s_set[S_SCK_F] = a_set[A_STB_F];
    s_set[S_SCK_R] = a_set[A_STB_R];
    s_set[S_LEN]   = a_set[A_LEN];
    s_set[S_TAIL]  = chipsel_release_setting;
  end

  adst_edge_cmp #(.N(N_ACC), .WHOLE(ACC_WHOLE)) u_acc_cmp (
    .step(acc_if.cmp), .setting(a_set), .reached(ra));
  adst_edge_cmp #(.N(N_SLOT), .WHOLE(SLOT_WHOLE)) u_slot_cmp (
    .step(slot_if.cmp), .setting(s_set), .reached(rs));

  adst_pin_sync #(.W(DW)) u_par_sync (.core_clk(core_clk), .rst(rst),
    .d(par_data_in), .q(par_in_s));
  adst_pin_sync #(.W(1)) u_ser_sync (.core_clk(core_clk), .rst(rst),
    .d(serial_data_in), .q(ser_in_s));

  assign slot_end = (state_r == ST_SHIFT) && rs[S_LEN];
  assign last_bit = (bitcnt_r == 8'(SER_BITS - 1));

  // access sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (take) state_nxt = ST_LEAD;
      ST_LEAD: begin
        if (is_ser && ra[A_OFFSET]) state_nxt = ST_SHIFT;
        else if (!is_ser && ra[A_LEN]) state_nxt = ST_END;
      end
      ST_SHIFT: if (slot_end && last_bit) state_nxt = ST_TAIL;
      ST_TAIL: if (rs[S_TAIL]) state_nxt = ST_END;
      ST_END: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      kind_r  <= KIND_READ;
      wdata_r <= '0;
    end else if (take) begin
      kind_r  <= access_kind;
      wdata_r <= access_wdata;
    end
  end

  // parallel read sample, taken once per access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sampled_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      sampled_r <= 1'b0;
    end else if (ra[A_SAMPLE]) begin
      sampled_r <= 1'b1;
    end
  end

  // serial bit capture at the rising clock edge of each slot
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rose_r <= 1'b0;
      bit_r  <= 1'b0;
    end else if (slot_clr) begin
      rose_r <= 1'b0;
    end else if (state_r == ST_SHIFT && rs[S_SCK_R] && !rose_r) begin
      rose_r <= 1'b1;
      bit_r  <= ser_in_s;
    end
  end

  // shift register and bit count, msb first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_r  <= '0;
      bitcnt_r <= 8'h00;
    end else if (take) begin
      shift_r  <= access_wdata << (DW - SER_BITS);
      bitcnt_r <= 8'h00;
    end else if (slot_end) begin
      shift_r  <= {shift_r[DW-2:0], bit_r};
      bitcnt_r <= bitcnt_r + 8'h01;
    end
  end

  // read word and completion pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      access_rdata <= '0;
      access_done  <= 1'b0;
    end else begin
      access_done <= (state_r == ST_END);
      if (!is_ser && is_read && ra[A_SAMPLE] && !sampled_r &&
          state_r == ST_LEAD) begin
        access_rdata <= par_in_s;
      end else if (is_ser && is_read && state_r == ST_END) begin
        access_rdata <= shift_r;
      end
    end
  end

  // active-sense strobe levels; nothing is active while idle
  always_comb begin
    cs_act  = 1'b0;
    rs_act  = 1'b0;
    rd_act  = 1'b0;
    wr_act  = 1'b0;
    sck_act = 1'b0;
    stb_act = ra[A_STB_F] && !ra[A_STB_R];
    if (!is_ser && state_r == ST_LEAD) begin
      cs_act = ra[A_CS_F] && !ra[A_CS_R];
      rs_act = (kind_r == KIND_ADDR) &&
               ra[A_RS_F] && !ra[A_RS_R];
      if (interface_mode == MODE_P68) begin
        rd_act = is_read;
        wr_act = stb_act;
      end else begin
        rd_act = is_read && stb_act;
        wr_act = !is_read && stb_act;
      end
    end else if (is_ser && state_r != ST_IDLE && state_r != ST_END) begin
      cs_act  = ra[A_CS_F];
      rs_act  = (interface_mode == MODE_S5) && (kind_r == KIND_ADDR) &&
                ra[A_SRS_AS] && !ra[A_SRS_RL];
      sck_act = (state_r == ST_SHIFT) &&
                rs[S_SCK_F] && !rs[S_SCK_R];
    end
  end

  // pin registers; reset leaves every strobe high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chip_select_pin  <= PIN_RST;
      register_select  <= PIN_RST;
      read_strobe_pin  <= PIN_RST;
      write_strobe_pin <= PIN_RST;
      serial_clock_pin <= PIN_RST;
    end else begin
      chip_select_pin  <= cs_act ~^ strobe_polarity_select[STB_CS];
      register_select  <= rs_act ~^ strobe_polarity_select[STB_RS];
      read_strobe_pin  <= rd_act ~^ strobe_polarity_select[STB_RD];
      write_strobe_pin <= wr_act ~^ strobe_polarity_select[STB_WR];
      serial_clock_pin <= sck_act ~^ strobe_polarity_select[POL_SCK];
    end
  end

  // data pins: parallel bus for writes, serial line per wire count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      par_data_out              <= '0;
      par_data_oe               <= 1'b0;
      serial_data_out           <= 1'b0;
      serial_data_output_enable <= 1'b0;
    end else begin
      par_data_out    <= wdata_r;
      par_data_oe     <= !is_ser && !is_read && (state_r == ST_LEAD);
      serial_data_out <= shift_r[DW-1];
      if (!is_ser || state_r == ST_IDLE || state_r == ST_END) begin
        serial_data_output_enable <= 1'b0;
      end else if (interface_mode == MODE_S3) begin
        serial_data_output_enable <= !is_read;
      end else begin
        serial_data_output_enable <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verification/adst_timing_gen_asserts.sv ====
// port checker for the display strobe timing generator
// assumes it is bound into every adst_timing_gen instance
`timescale 1ns/1ns
`default_nettype none
module adst_timing_gen_asserts #(
  parameter int HALF_DIV = 1, // core cycles per half step
  parameter int SER_BITS = 8  // serial bits
) (
  input wire logic                     core_clk,   // clock
  input wire logic                     rst,        // reset
  input wire adst_pkg::adst_mode_type  interface_mode, // form
  input wire logic [adst_pkg::NPOL-1:0] strobe_polarity_select, // levels
  input wire logic [adst_pkg::SW-1:0]  base_clock_divider_setting, // P
  input wire logic [adst_pkg::NKIND-1:0][adst_pkg::SW-1:0]
                                       interface_cycle_length_setting,
  input wire logic [adst_pkg::SW-1:0]  serial_clock_delay_setting, // delay
  input wire logic [adst_pkg::SW-1:0]  chipsel_release_setting, // tail
  input wire logic                     access_req,   // request
  input wire adst_pkg::adst_kind_type  access_kind,  // kind
  input wire logic                     access_ready, // idle
  input wire logic                     access_done,  // done
  input wire logic                     chip_select_pin,  // cs
  input wire logic                     register_select,  // rs
  input wire logic                     read_strobe_pin,  // rd
  input wire logic                     write_strobe_pin, // wr
  input wire logic                     par_data_oe,      // bus drive
  input wire logic                     serial_clock_pin, // sclk
  input wire logic                     serial_data_output_enable // drive
);
  import adst_pkg::*;
  int              pd;
  int              cnt;
  int              expv;
  logic [1:0]      idle_n;
  logic [NPOL-1:0] pol_q;
  adst_kind_type   kind_q;
  // divider with zero read as one
  assign pd = (base_clock_divider_setting == 8'h00) ? 1
            : int'(base_clock_divider_setting);
  // whole setting counted in half steps
  function automatic int cw(input int x);
    return 2 * ((x + pd - 1) / pd);
  endfunction
  // cycles since the take edge and the expected access length
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      expv <= 0;
      kind_q <= KIND_READ;
    end else if (access_req && access_ready) begin
      cnt <= 1;
      kind_q <= access_kind;
      expv <= 3 + HALF_DIV * ((interface_mode inside {MODE_P80, MODE_P68})
        ? cw(interface_cycle_length_setting[access_kind])
        : cw(serial_clock_delay_setting) + cw(chipsel_release_setting)
        + SER_BITS * cw(interface_cycle_length_setting[access_kind]));
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
    end
  end
  // idle cycles under unchanged polarity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_n <= 2'h0;
      pol_q <= 5'h00;
    end else begin
      pol_q <= strobe_polarity_select;
      if (!access_ready || strobe_polarity_select != pol_q) idle_n <= 2'h0;
      else if (idle_n != 2'h3) idle_n <= idle_n + 2'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_done_pulse: assert property (access_done |=> !access_done)
    else $error("done over one cycle");
  a_take_busy: assert property (
    access_req && access_ready |=> !access_ready)
    else $error("ready after take");
  a_cycle_len: assert property (
    access_done |-> cnt == expv)
    else $error("access length off");
  a_idle_quiet: assert property (
    idle_n == 2'h3 |-> chip_select_pin != strobe_polarity_select[STB_CS]
    && read_strobe_pin != strobe_polarity_select[STB_RD]
    && write_strobe_pin != strobe_polarity_select[STB_WR]
    && serial_clock_pin != strobe_polarity_select[POL_SCK])
    else $error("strobe active in idle");
  a_par_oe: assert property (
    par_data_oe && !access_ready |-> interface_mode inside {MODE_P80, MODE_P68})
    else $error("bus driven in serial");
  a_ser_oe: assert property (
    serial_data_output_enable && !access_ready
    |-> !(interface_mode inside {MODE_P80, MODE_P68}))
    else $error("serial driven in parallel");
  a_read_no_wr: assert property (
    kind_q == KIND_READ && interface_mode == MODE_P80 && !access_ready
    |-> write_strobe_pin != strobe_polarity_select[STB_WR])
    else $error("write strobe in read");
  a_rs_quiet: assert property (
    kind_q != KIND_ADDR && !access_ready
    |-> register_select != strobe_polarity_select[STB_RS])
    else $error("rs outside address write");
endmodule
bind adst_timing_gen adst_timing_gen_asserts #(.HALF_DIV(HALF_DIV),
  .SER_BITS(SER_BITS)) adst_timing_gen_asserts_i (.*);
`default_nettype wire

// ==== verification/adst_panel_model.sv ====
// display panel model: parallel read data and serial shift partner
// assumes strobe levels are judged against the polarity bits
`timescale 1ns/1ns
`default_nettype none
module adst_panel_model #(
  parameter int BITS = 8 // serial bits
) (
  input wire logic        cs,   // chip select pin
  input wire logic        rd,   // read strobe pin
  input wire logic        sclk, // serial clock pin
  input wire logic        sdo,  // serial line from the port
  input wire logic [4:0]  pol,  // polarity bits
  input wire logic [15:0] word, // word the panel returns
  output logic     [15:0] pdi,  // bus to the port
  output logic            sdi,  // serial line to the port
  output logic     [15:0] cap,  // bits taken in
  output int              n     // serial clock rises
);
  logic [15:0] sh;
  // word shown only while selected and read, else inverse of last
  always @(cs, rd, pol, word)
    if (cs == pol[0] && rd == pol[2]) pdi = word;
    else pdi = ~pdi;
  // bit out at each fall, bit in at each rise, separate lines
  always @(sclk)
    if (cs == pol[0] && sclk == pol[4]) begin
      sdi = sh[15];
      sh = sh << 1;
    end else if (cs == pol[0]) begin
      cap = {cap[14:0], sdo};
      n++;
    end
  // selection loads the word, release toggles the line
  always @(cs)
    if (cs == pol[0]) begin
      sh = word << (16 - BITS);
      cap = 16'h0000;
      n = 0;
    end else sdi = ~sdi;
endmodule
`default_nettype wire

// ==== verification/test_async_display_strobe_timing.sv ====
// bench for the strobe timing generator against a panel model
// assumes the checker binds itself in from its own file
`timescale 1ns/1ns
`default_nettype none
module test_async_display_strobe_timing;
  import adst_pkg::*;
  localparam int H = 1;
  localparam int SB = 8;
  logic core_clk, rst, access_req, access_ready, access_done, sdw;
  logic chip_select_pin, register_select, read_strobe_pin, p_sdi;
  logic write_strobe_pin, par_data_oe, serial_clock_pin, serial_data_out;
  logic serial_data_output_enable, serial_data_in;
  logic [NPOL-1:0] strobe_polarity_select;
  logic [SW-1:0] base_clock_divider_setting, read_sample_setting;
  logic [SW-1:0] serial_clock_delay_setting, regsel_assert_setting;
  logic [SW-1:0] regsel_release_setting, chipsel_release_setting;
  logic [NKIND-1:0][SW-1:0] interface_cycle_length_setting;
  logic [NSTB-1:0][SW-1:0] strobe_fall_setting, strobe_rise_setting;
  adst_mode_type interface_mode;
  adst_kind_type access_kind;
  logic [DW-1:0] access_wdata, access_rdata, par_data_out, par_data_in;
  logic [DW-1:0] word, cap;
  logic [3:0] act, act_p;
  int n_fail, checked, cyc, t0, tdn, ncl, pp, m, d, f[4], on_t[4], off_t[4];
  adst_timing_gen #(.HALF_DIV(H), .SER_BITS(SB)) adst_timing_gen_i (.*);
  adst_panel_model #(.BITS(SB)) adst_panel_model_i (.cs(chip_select_pin),
    .rd(read_strobe_pin), .sclk(serial_clock_pin), .sdo(sdw),
    .pol(strobe_polarity_select), .word(word), .pdi(par_data_in),
    .sdi(p_sdi), .cap(cap), .n(ncl));
  // three-wire form shares one line
  assign sdw = serial_data_output_enable ? serial_data_out : p_sdi;
  assign serial_data_in = (interface_mode == MODE_S3) ? sdw : p_sdi;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // edge times of cs rs rd wr activity, take and done cycles
  always @(posedge core_clk) begin
    act = ~({write_strobe_pin, read_strobe_pin, register_select,
      chip_select_pin} ^ strobe_polarity_select[3:0]);
    for (int i = 0; i < 4; i++) begin
      if (act[i] && !act_p[i]) on_t[i] = cyc;
      if (!act[i] && act_p[i]) off_t[i] = cyc;
    end
    act_p = act;
    if (access_done) tdn = cyc;
    if (access_req && access_ready) begin
      t0 = cyc;
      tdn = 0;
    end
    cyc++;
  end
  task automatic chk(input string nm, input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic int rr(int lo, int hi);
    return lo + int'($urandom % (hi - lo + 1));
  endfunction
  function automatic int h2(int x);
    return (2 * x + pp - 1) / pp;
  endfunction
  function automatic int w2(int x);
    return 2 * ((x + pp - 1) / pp);
  endfunction
  // one access; st is its expected length in half steps
  task automatic acc(input adst_kind_type k, input int st);
    @(negedge core_clk);
    strobe_polarity_select = 5'($urandom);
    word = 16'($urandom);
    @(negedge core_clk);
    access_req = 1'b1;
    access_kind = k;
    access_wdata = 16'($urandom);
    @(negedge core_clk);
    access_req = 1'b0;
    for (int i = 0; i < 500 && tdn == 0; i++) @(negedge core_clk);
    chk("length", tdn-t0, 3+H*st);
  endtask
  initial begin
    void'($urandom(27));
    rst = 1'b1;
    access_req = 1'b0;
    access_kind = KIND_READ;
    {access_wdata, word} = 32'h00000000;
    interface_mode = MODE_P80;
    strobe_polarity_select = 5'h00;
    base_clock_divider_setting = 8'h01;
    interface_cycle_length_setting = '0;
    {strobe_fall_setting, strobe_rise_setting} = '0;
    {read_sample_setting, serial_clock_delay_setting, regsel_assert_setting,
      regsel_release_setting, chipsel_release_setting} = '0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    @(negedge core_clk);
    chk("idle cs", chip_select_pin, 1'b1);
    // every kind in both parallel forms, random divider and edges
    for (int n = 0; n < 6; n++) begin
      interface_mode = adst_mode_type'(n % 2);
      pp = rr(1, 3);
      m = rr(12, 16);
      base_clock_divider_setting = 8'(pp);
      for (int i = 0; i < 4; i++) begin
        f[i] = rr(0, 2);
        strobe_fall_setting[i] = 8'(f[i]);
        if (i < 3) interface_cycle_length_setting[i] = 8'(m + 2 * i);
      end
      strobe_rise_setting = {4{8'(m - 1)}};
      read_sample_setting = 8'(m - 1);
      acc(adst_kind_type'(n % 3), w2(m + 2 * (n % 3)));
      chk("wdata", par_data_out, access_wdata);
      chk("cs", off_t[0]-on_t[0], H*(h2(m-1)-h2(f[0])));
      if (n % 3 == 1) begin
        chk("rs", on_t[1]-on_t[0], H*(h2(f[1])-h2(f[0])));
        chk("rs up", off_t[1]-on_t[1], H*(h2(m-1)-h2(f[1])));
      end
      if (n == 0) chk("rd", on_t[2]-on_t[0], H*(h2(f[2])-h2(f[0])));
      if (n % 3 == 0) chk("rdata", access_rdata, word);
    end
    // serial write and read in each serial form
    pp = 1;
    base_clock_divider_setting = 8'h01;
    interface_cycle_length_setting = {3{8'h06}};
    strobe_fall_setting = {8'h01, 8'h01, 8'h00, 8'h00};
    strobe_rise_setting = {8'h05, 8'h05, 8'h00, 8'h00};
    {regsel_assert_setting, regsel_release_setting} = 16'h0104;
    for (int s = 2; s < 5; s++) begin
      interface_mode = adst_mode_type'(s);
      d = rr(0, 3);
      serial_clock_delay_setting = 8'(d);
      chipsel_release_setting = 8'(d + 1);
      acc(KIND_ADDR, w2(d) + SB * 12 + w2(d + 1));
      chk("bits", cap[SB-1:0], access_wdata[SB-1:0]);
      chk("clocks", ncl, SB);
      if (s == 4) chk("srs", off_t[1]-on_t[1], H*6);
      acc(KIND_READ, w2(d) + SB * 12 + w2(d + 1));
      chk("rbits", access_rdata[SB-1:0], word[SB-1:0]);
    end
    finish_test;
  end
  // cut a hang short
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
